// ### inc/blc_map.svh
// register offsets, field positions, reset values and encodings
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH

// register offsets on the serial control register port
`define BLC_ADDR_DAYLIGHT_DIM 8'h0A
`define BLC_ADDR_OFFICE_MAX 8'h0B
`define BLC_ADDR_OFFICE_DIM 8'h0C

// current code field and reserved bit
`define BLC_CODE_MSB 6
`define BLC_CODE_LSB 0
`define BLC_RSVD_BIT 7

// reset values and unmapped read answer
`define BLC_RST_REG 8'h00
`define BLC_RST_CODE 7'h00
`define BLC_UNMAPPED_RD 8'h00

// ambient level encodings
`define BLC_LVL_DAYLIGHT 2'h1
`define BLC_LVL_OFFICE 2'h2
`define BLC_LVL_DARK 2'h3

// transfer law encodings
`define BLC_LAW_LINEAR 2'h0
`define BLC_LAW_SQUARE 2'h1
`define BLC_LAW_CUBIC10 2'h2
`define BLC_LAW_CUBIC11 2'h3

// current scale: full code gives 30 mA, expressed in microamps
`define BLC_FULL_UA 32'h0000_7530
`define BLC_FULL_CODE 32'h0000_007F
`define BLC_FULL_CODE_SQ 32'h0000_3F01

`endif

// ### inc/blc_pkg.sv
// types shared by the backlight current register block
package blc_pkg;

    // dim state, one-hot
    typedef enum logic [1:0] {
        BLC_ST_BRIGHT = 2'b01,
        BLC_ST_DIMMED = 2'b10
    } blc_state_t;

    // fade time step class handed to the fade engine
    typedef enum logic [1:0] {
        BLC_STEP_LINEAR = 2'h0,
        BLC_STEP_CUBIC10 = 2'h1,
        BLC_STEP_CUBIC11 = 2'h2
    } blc_step_t;

endpackage

// ### rtl/blc_law_map.sv
// maps a current code to sink current under the selected transfer law
`timescale 1ns/1ps
`include "blc_map.svh"

module blc_law_map #(
    parameter int CODE_W = 7,
    parameter int UA_W = 15
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // code and law
    input wire logic [CODE_W-1:0] code_in,
    input wire logic [1:0] law_in,
    // mapped current and step class
    output logic [UA_W-1:0] current_ua_out,
    output blc_pkg::blc_step_t step_out
);

    logic [31:0] lin_prod;
    logic [31:0] sq_prod;
    logic [31:0] nxt_ua;
    logic square_law;

    // cubic laws share the square current curve; only their step differs
    assign square_law = (law_in != `BLC_LAW_LINEAR);

    // linear: equal steps; square: grows with code squared; both end at 30
    always_comb begin
        lin_prod = 32'(code_in) * `BLC_FULL_UA;
        sq_prod = 32'(code_in) * 32'(code_in) * `BLC_FULL_UA;
        if (square_law) begin
            nxt_ua = sq_prod / `BLC_FULL_CODE_SQ;
        end else begin
            nxt_ua = lin_prod / `BLC_FULL_CODE;
        end
    end

    // registered so the sink sees a clean value, one cycle after the code
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            current_ua_out <= '0;
        end else begin
            current_ua_out <= nxt_ua[UA_W-1:0];
        end
    end

    // time step per code during a fade, by law
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            step_out <= blc_pkg::BLC_STEP_LINEAR;
        end else begin
            case (law_in)
                `BLC_LAW_CUBIC10: step_out <= blc_pkg::BLC_STEP_CUBIC10;
                `BLC_LAW_CUBIC11: step_out <= blc_pkg::BLC_STEP_CUBIC11;
                default: step_out <= blc_pkg::BLC_STEP_LINEAR;
            endcase
        end
    end

endmodule

// ### rtl/blc_regs.sv
// backlight level current registers, dim control and current selection
`timescale 1ns/1ps
`include "blc_map.svh"

module blc_regs #(
    parameter int CODE_W = 7,
    parameter int UA_W = 15
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register port from the serial control interface
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_hit_out,
    // codes held by neighbouring register blocks
    input wire logic [CODE_W-1:0] daylight_max_code_in,
    input wire logic [CODE_W-1:0] dark_max_code_in,
    input wire logic [CODE_W-1:0] dark_dim_code_in,
    // ambient level, law and dim control
    input wire logic [1:0] ambient_level_in,
    input wire logic [1:0] law_in,
    input wire logic dim_en_in,
    input wire logic dim_timeout_in,
    input wire logic wake_in,
    // backlight current to the sink
    output logic [CODE_W-1:0] bl_code_out,
    output logic [UA_W-1:0] bl_current_ua_out,
    output blc_pkg::blc_step_t bl_step_out,
    output logic dimmed_out,
    output logic code_change_out
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [CODE_W-1:0] daylight_dim_code_ff;
    logic [CODE_W-1:0] office_max_code_ff;
    logic [CODE_W-1:0] office_dim_code_ff;
    logic [7:0] rdata_ff;
    logic hit_ff;
    logic wr_daylight_dim;
    logic wr_office_max;
    logic wr_office_dim;
    logic addr_mapped;

    // address decode for the three registers of this block
    assign wr_daylight_dim = reg_wr_in &&
        (reg_addr_in == `BLC_ADDR_DAYLIGHT_DIM);
    assign wr_office_max = reg_wr_in &&
        (reg_addr_in == `BLC_ADDR_OFFICE_MAX);
    assign wr_office_dim = reg_wr_in &&
        (reg_addr_in == `BLC_ADDR_OFFICE_DIM);
    assign addr_mapped = (reg_addr_in == `BLC_ADDR_DAYLIGHT_DIM) ||
        (reg_addr_in == `BLC_ADDR_OFFICE_MAX) ||
        (reg_addr_in == `BLC_ADDR_OFFICE_DIM);

    // daylight dim code; the reserved bit is simply not stored
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            daylight_dim_code_ff <= `BLC_RST_CODE;
        end else if (wr_daylight_dim) begin
            daylight_dim_code_ff <=
                reg_wdata_in[`BLC_CODE_MSB:`BLC_CODE_LSB];
        end
    end

    // office maximum code
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            office_max_code_ff <= `BLC_RST_CODE;
        end else if (wr_office_max) begin
            office_max_code_ff <=
                reg_wdata_in[`BLC_CODE_MSB:`BLC_CODE_LSB];
        end
    end

    // office dim code
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            office_dim_code_ff <= `BLC_RST_CODE;
        end else if (wr_office_dim) begin
            office_dim_code_ff <=
                reg_wdata_in[`BLC_CODE_MSB:`BLC_CODE_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read-back

    logic [7:0] nxt_rdata;

    // reserved bit 7 reads as zero; unmapped offsets read the fixed answer
    always_comb begin
        nxt_rdata = `BLC_UNMAPPED_RD;
        case (reg_addr_in)
            `BLC_ADDR_DAYLIGHT_DIM: nxt_rdata = {1'b0, daylight_dim_code_ff};
            `BLC_ADDR_OFFICE_MAX: nxt_rdata = {1'b0, office_max_code_ff};
            `BLC_ADDR_OFFICE_DIM: nxt_rdata = {1'b0, office_dim_code_ff};
            default: nxt_rdata = `BLC_UNMAPPED_RD;
        endcase
    end

    // read data is captured on the read strobe and held until the next one
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_ff <= `BLC_RST_REG;
            hit_ff <= 1'b0;
        end else if (reg_rd_in) begin
            rdata_ff <= nxt_rdata;
            hit_ff <= addr_mapped;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign reg_hit_out = hit_ff;

    ////////////////////////////////////////////////////////////////////////
    // dim state

    blc_pkg::blc_state_t state_ff;
    blc_pkg::blc_state_t nxt_state;

    // dim enable forces the dim state and holds it; a timeout enters it
    // and only wake activity leaves it, so a quiet panel stays dimmed;
    // a timeout in the same cycle as wake wins, so dimming is never lost
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            blc_pkg::BLC_ST_BRIGHT: begin
                if (dim_en_in || dim_timeout_in) begin
                    nxt_state = blc_pkg::BLC_ST_DIMMED;
                end
            end
            blc_pkg::BLC_ST_DIMMED: begin
                if (!dim_en_in && !dim_timeout_in && wake_in) begin
                    nxt_state = blc_pkg::BLC_ST_BRIGHT;
                end
            end
            default: nxt_state = blc_pkg::BLC_ST_BRIGHT;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_ff <= blc_pkg::BLC_ST_BRIGHT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // code selection

    logic [CODE_W-1:0] max_code;
    logic [CODE_W-1:0] dim_code;
    logic [CODE_W-1:0] nxt_code;
    logic [CODE_W-1:0] code_ff;
    logic change_ff;

    // maximum and dim codes of the level currently detected
    always_comb begin
        case (ambient_level_in)
            `BLC_LVL_OFFICE: begin
                max_code = office_max_code_ff;
                dim_code = office_dim_code_ff;
            end
            `BLC_LVL_DARK: begin
                max_code = dark_max_code_in;
                dim_code = dark_dim_code_in;
            end
            default: begin
                max_code = daylight_max_code_in;
                dim_code = daylight_dim_code_ff;
            end
        endcase
    end

    // the dim state picks the dim code, otherwise the level maximum
    assign nxt_code = (nxt_state == blc_pkg::BLC_ST_DIMMED) ?
        dim_code : max_code;

    // registered code; a change flag tells the fade engine to start
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            code_ff <= `BLC_RST_CODE;
            change_ff <= 1'b0;
        end else begin
            code_ff <= nxt_code;
            change_ff <= (nxt_code != code_ff);
        end
    end

    assign bl_code_out = code_ff;
    assign code_change_out = change_ff;
    assign dimmed_out = (state_ff == blc_pkg::BLC_ST_DIMMED);

    ////////////////////////////////////////////////////////////////////////
    // transfer law mapping

    // current follows the code by one more cycle, which keeps the divider
    // off the code register's timing path
    blc_law_map #(
        .CODE_W(CODE_W),
        .UA_W(UA_W)
    ) u_law_map (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .code_in(code_ff),
        .law_in(law_in),
        .current_ua_out(bl_current_ua_out),
        .step_out(bl_step_out)
    );

endmodule

// ### bench/blc_regs_asserts.sv
// concurrent checks on the ports of the backlight current register block
`timescale 1ns/1ps
`include "blc_map.svh"
module blc_regs_asserts #(
    parameter int CODE_W = 7,
    parameter int UA_W = 15
) (
    // clock and reset
    input wire logic sys_clk_in, rst_in,
    // register port
    input wire logic reg_wr_in, reg_rd_in, reg_hit_out,
    input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
    // level codes, ambient level and dim control
    input wire logic [CODE_W-1:0] daylight_max_code_in, dark_max_code_in,
    input wire logic [CODE_W-1:0] dark_dim_code_in, bl_code_out,
    input wire logic [1:0] ambient_level_in, law_in,
    input wire logic dim_en_in, dim_timeout_in, wake_in,
    // sink side
    input wire logic [UA_W-1:0] bl_current_ua_out,
    input wire blc_pkg::blc_step_t bl_step_out,
    input wire logic dimmed_out, code_change_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // one decode shared by the read checks
    wire mapped = reg_addr_in inside {`BLC_ADDR_DAYLIGHT_DIM,
        `BLC_ADDR_OFFICE_MAX, `BLC_ADDR_OFFICE_DIM};
    ////////////////////////////////////////////////////////////////////
    property p_hit; reg_rd_in && mapped |=> reg_hit_out && !reg_rdata_out[7];
    endproperty
    a_hit: assert property (p_hit) else $error("mapped read");
    property p_miss; reg_rd_in && !mapped |=> !reg_hit_out && !reg_rdata_out;
    endproperty
    a_miss: assert property (p_miss) else $error("unmapped read");
    property p_den; dim_en_in |=> dimmed_out; endproperty
    a_den: assert property (p_den) else $error("dim flag ignored");
    property p_tmo; dim_timeout_in |=> dimmed_out; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout ignored");
    // bright and staying bright in daylight means the daylight maximum drives the sink
    property p_day; !dimmed_out && !dim_en_in && !dim_timeout_in &&
        ambient_level_in == `BLC_LVL_DAYLIGHT |=>
        bl_code_out == $past(daylight_max_code_in); endproperty
    a_day: assert property (p_day) else $error("bright code");
    // law held three edges so code and law both reached the current
    property p_lin; (law_in == `BLC_LAW_LINEAR)[*3] |=>
        32'(bl_current_ua_out) == 32'($past(bl_code_out)) * 30000 / 127;
    endproperty
    a_lin: assert property (p_lin) else $error("linear current");
    property p_sq; (law_in != `BLC_LAW_LINEAR)[*3] |=> 32'(bl_current_ua_out)
        == 32'($past(bl_code_out)) * 32'($past(bl_code_out)) * 30000 / 16129;
    endproperty
    a_sq: assert property (p_sq) else $error("square current");
    property p_step; (law_in == `BLC_LAW_CUBIC11)[*2] |=>
        bl_step_out == blc_pkg::BLC_STEP_CUBIC11; endproperty
    a_step: assert property (p_step) else $error("step class");
    // the change pulse marks exactly the edges at which the code moved
    property p_chg; code_change_out == $changed(bl_code_out); endproperty
    a_chg: assert property (p_chg) else $error("change pulse");
endmodule
bind blc_regs blc_regs_asserts #(.CODE_W(CODE_W), .UA_W(UA_W)) u_chk (
    .sys_clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_hit_out, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .daylight_max_code_in, .dark_max_code_in,
    .dark_dim_code_in, .bl_code_out, .ambient_level_in, .law_in, .dim_en_in,
    .dim_timeout_in, .wake_in, .bl_current_ua_out, .bl_step_out, .dimmed_out,
    .code_change_out);

// ### bench/blc_regs_bench.sv
// self-checking bench for the backlight current register block
`timescale 1ns/1ps
`include "blc_map.svh"
module blc_regs_bench;
    logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, dim_en_in, wake_in;
    logic dim_timeout_in, reg_hit_out, dimmed_out, code_change_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [6:0] daylight_max_code_in, dark_max_code_in, dark_dim_code_in;
    logic [6:0] bl_code_out;
    logic [1:0] ambient_level_in, law_in;
    logic [14:0] bl_current_ua_out;
    blc_pkg::blc_step_t bl_step_out;
    int errors, compares;
    blc_regs u_blc_regs (
        .sys_clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
        .reg_wdata_in, .reg_rdata_out, .reg_hit_out, .daylight_max_code_in,
        .dark_max_code_in, .dark_dim_code_in, .ambient_level_in, .law_in,
        .dim_en_in, .dim_timeout_in, .wake_in, .bl_code_out,
        .bl_current_ua_out, .bl_step_out, .dimmed_out, .code_change_out);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [14:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // one-cycle write strobe, released on the next edge
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data is registered, so look just after the taking edge
    task automatic rd(input logic [7:0] a, e, input logic h);
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata_out);
        chk("hit", h, reg_hit_out);
    endtask
    // covers the two-cycle path from level and dim inputs through the code to current
    task automatic settle;
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(`BLC_ADDR_DAYLIGHT_DIM, 8'h00, 1'b1);
        wr(`BLC_ADDR_DAYLIGHT_DIM, 8'h8A);
        wr(`BLC_ADDR_OFFICE_MAX, 8'hFF);
        wr(`BLC_ADDR_OFFICE_DIM, 8'h93);
        wr(8'h0D, 8'h55);
        rd(`BLC_ADDR_DAYLIGHT_DIM, 8'h0A, 1'b1);
        rd(`BLC_ADDR_OFFICE_MAX, 8'h7F, 1'b1);
        rd(`BLC_ADDR_OFFICE_DIM, 8'h13, 1'b1);
        rd(8'h0D, 8'h00, 1'b0);
    endtask
    task automatic t_levels;
        settle();
        chk("code", 15'h007F, bl_code_out);
        chk("current", 15'h7530, bl_current_ua_out);
        @(posedge sys_clk_in);
        ambient_level_in <= `BLC_LVL_DAYLIGHT;
        @(posedge sys_clk_in);
        #1;
        chk("change", 15'h0001, code_change_out);
        settle();
        chk("change", 15'h0000, code_change_out);
        chk("code", 15'h0001, bl_code_out);
        chk("current", 15'h00EC, bl_current_ua_out);
        for (int l = 1; l < 4; l++) begin
            @(posedge sys_clk_in);
            law_in <= 2'(l);
            settle();
            chk("current", 15'h0001, bl_current_ua_out);
            chk("step", 15'(l - 1), bl_step_out);
        end
        @(posedge sys_clk_in);
        ambient_level_in <= `BLC_LVL_DARK;
        settle();
        chk("code", 15'h0040, bl_code_out);
    endtask
    task automatic t_dim;
        @(posedge sys_clk_in);
        ambient_level_in <= `BLC_LVL_OFFICE;
        dim_en_in <= 1'b1;
        settle();
        chk("code", 15'h0013, bl_code_out);
        @(posedge sys_clk_in);
        ambient_level_in <= `BLC_LVL_DAYLIGHT;
        law_in <= `BLC_LAW_LINEAR;
        wake_in <= 1'b1;
        settle();
        chk("dimmed", 15'h0001, dimmed_out);
        chk("code", 15'h000A, bl_code_out);
        chk("current", 15'h093A, bl_current_ua_out);
        @(posedge sys_clk_in);
        dim_en_in <= 1'b0;
        wake_in <= 1'b1;
        @(posedge sys_clk_in);
        wake_in <= 1'b0;
        settle();
        chk("dimmed", 15'h0000, dimmed_out);
        @(posedge sys_clk_in);
        dim_timeout_in <= 1'b1;
        @(posedge sys_clk_in);
        dim_timeout_in <= 1'b0;
        settle();
        chk("dimmed", 15'h0001, dimmed_out);
        chk("code", 15'h000A, bl_code_out);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    // a hang runs far past the 66 cycles the tests need
    initial begin
        repeat (2000) @(posedge sys_clk_in);
        errors++;
        tally_and_finish();
    end
    initial begin
        rst_in = 1'b1;
        {reg_wr_in, reg_rd_in, dim_en_in, dim_timeout_in, wake_in} = 5'h00;
        {reg_addr_in, reg_wdata_in} = 16'h0000;
        {dark_max_code_in, dark_dim_code_in} = 14'h0000;
        daylight_max_code_in = 7'h01;
        dark_max_code_in = 7'h40;
        ambient_level_in = `BLC_LVL_OFFICE;
        law_in = `BLC_LAW_LINEAR;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_levels();
        t_dim();
        tally_and_finish();
    end
endmodule
